// ===== shared/irq_prio_pkg.sv
/*
 * irq_prio_pkg: register map, field layout and carrier types for the
 * interrupt priority configuration bank.
 * Assumes a 32-bit APB master and one clock shared with the sources.
 */
package irq_prio_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int NUM_REGS = 3;
  localparam int LANES    = 4;
  localparam int NUM_SRC  = NUM_REGS * LANES;
  localparam int LANE_W   = 8;
  localparam int LEVEL_W  = 3;
  localparam int SUB_W    = 2;
  localparam int LEVEL_LSB = 2;
  localparam int SUB_LSB   = 0;

  localparam logic [ADDR_W-1:0] IRQ_PRIO_CTRL_SIX_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_PRIO_CTRL_SEVEN_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_PRIO_CTRL_EIGHT_OFS = 8'h08;

  localparam logic [LEVEL_W-1:0] LEVEL_DISABLED = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET    = 3'h0;
  localparam logic [SUB_W-1:0]   SUB_RESET      = 2'h0;
  localparam logic [DATA_W-1:0]  READ_ZERO      = 32'h0000_0000;

  // source index = register number * 4 + byte lane
  typedef enum logic [3:0] {
    SRC_SERIAL_PORT_A   = 4'h0,
    SRC_TWO_WIRE_PORT_A = 4'h1,
    SRC_PIN_CHANGE      = 4'h2,
    SRC_CONVERTER       = 4'h3,
    SRC_PARALLEL_PORT   = 4'h4,
    SRC_COMPARATOR_A    = 4'h5,
    SRC_COMPARATOR_B    = 4'h6,
    SRC_SYNC_SERIAL_B   = 4'h7,
    SRC_SERIAL_PORT_B   = 4'h8,
    SRC_TWO_WIRE_PORT_B = 4'h9,
    SRC_CLOCK_MONITOR   = 4'hA,
    SRC_CALENDAR_CLOCK  = 4'hB
  } source_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic [SUB_W-1:0]   sublevel;
  } src_cfg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [LANES-1:0]  pstrb;
  } apb_req_t;

endpackage : irq_prio_pkg

// ===== verilog/irq_priority_config_bank.sv
/*
 * irq_priority_config_bank: three priority control registers holding a
 * level and sublevel for each of twelve interrupt sources, on APB.
 * Assumes irqRequest comes from logic on mclk; arbitration lives outside.
 */
// Overview of operation
// - nonzero 3-bit level code gives priority 1 to 7, value equals level
// - level code zero disables the source; eligible drops one cycle after its level becomes zero
// - 2-bit sublevel code gives subpriority 0 to 3 directly
// - converter: level bits 28-26, sublevel 25-24 of the first register
// - first register: pin change 20-18/17-16, port a 12-10/9-8, 4-2/1-0
// - second register: sync serial b, comparator b, a, parallel port lanes
// - third register: calendar 28-26, two-wire b 12-10/9-8, serial b 4-2/1-0
// - power-on reset clears all level and sublevel bits, sources disabled
`timescale 1ns/1ps
`default_nettype none

module irq_priority_config_bank #(
  parameter int NUM_SRC = irq_prio_pkg::NUM_SRC
) (
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  input  wire irq_prio_pkg::apb_req_t            apbReq,
  output logic [irq_prio_pkg::DATA_W-1:0]        prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [NUM_SRC-1:0]                irqRequest,
  output irq_prio_pkg::src_cfg_t [NUM_SRC-1:0]   sourceCfg,
  output logic [NUM_SRC-1:0]                     eligible
);

  typedef struct packed {
    irq_prio_pkg::src_cfg_t [NUM_SRC-1:0] cfg;
    logic [irq_prio_pkg::DATA_W-1:0]      rdata;
    logic                                 rerr;
    logic [NUM_SRC-1:0]                   eligible;
  } state_t;

  state_t state;
  state_t next_state;

  logic       hit;
  logic [1:0] hitReg;
  logic       setup;
  logic       access;

  // address decode; unmapped addresses answer with pslverr
  always_comb begin
    hit    = 1'b1;
    hitReg = 2'h0;
    if (apbReq.paddr == irq_prio_pkg::IRQ_PRIO_CTRL_SIX_OFS) begin
      hitReg = 2'h0;
    end else if (apbReq.paddr == irq_prio_pkg::IRQ_PRIO_CTRL_SEVEN_OFS) begin
      hitReg = 2'h1;
    end else if (apbReq.paddr == irq_prio_pkg::IRQ_PRIO_CTRL_EIGHT_OFS) begin
      hitReg = 2'h2;
    end else begin
      hit = 1'b0;
    end
  end

  assign setup  = apbReq.psel && !apbReq.penable;
  assign access = apbReq.psel && apbReq.penable;

  always_comb begin
    int lane;
    int regNum;
    lane   = 0;
    regNum = 0;
    next_state = state;
    // read data is captured in the setup cycle so prdata comes from a flop
    if (setup) begin
      next_state.rdata = irq_prio_pkg::READ_ZERO;
      next_state.rerr  = !hit;
      for (int i = 0; i < NUM_SRC; i++) begin
        lane   = i % irq_prio_pkg::LANES;
        regNum = i / irq_prio_pkg::LANES;
        if (hit && (regNum == int'(hitReg))) begin
          // lane layout bits 7-5 read zero
          next_state.rdata[lane*irq_prio_pkg::LANE_W
                           +irq_prio_pkg::LEVEL_LSB+:irq_prio_pkg::LEVEL_W]
            = state.cfg[i].level;
          next_state.rdata[lane*irq_prio_pkg::LANE_W
                           +irq_prio_pkg::SUB_LSB+:irq_prio_pkg::SUB_W]
            = state.cfg[i].sublevel;
        end
      end
    end
    // write takes effect on the access edge, per byte strobe
    if (access && apbReq.pwrite && hit) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        lane   = i % irq_prio_pkg::LANES;
        regNum = i / irq_prio_pkg::LANES;
        if ((regNum == int'(hitReg)) && apbReq.pstrb[lane]) begin
          // reserved bits are not stored, so any value written is dropped
          next_state.cfg[i].level = apbReq.pwdata[lane*irq_prio_pkg::LANE_W
            +irq_prio_pkg::LEVEL_LSB+:irq_prio_pkg::LEVEL_W];
          next_state.cfg[i].sublevel = apbReq.pwdata[lane*irq_prio_pkg::LANE_W
            +irq_prio_pkg::SUB_LSB+:irq_prio_pkg::SUB_W];
        end
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      next_state.eligible[i] = irqRequest[i]
        && (state.cfg[i].level != irq_prio_pkg::LEVEL_DISABLED);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        state.cfg[i].level    <= irq_prio_pkg::LEVEL_RESET;
        state.cfg[i].sublevel <= irq_prio_pkg::SUB_RESET;
      end
      state.rdata    <= irq_prio_pkg::READ_ZERO;
      state.rerr     <= 1'b0;
      state.eligible <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pready    = 1'b1;
  assign prdata    = state.rdata;
  assign pslverr   = access && state.rerr;
  assign sourceCfg = state.cfg;
  assign eligible  = state.eligible;

endmodule : irq_priority_config_bank

`default_nettype wire

// ===== verif/irq_prio_bank_sva.sv
/* irq_prio_bank_sva: port checks of the priority bank.
   Assumes a bind onto the bank and one clock, mclk. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_bank_sva #(parameter int NUM_SRC = 12) (
  input wire logic                                 mclk,
  input wire logic                                 rst_b,
  input wire irq_prio_pkg::apb_req_t               apbReq,
  input wire logic [31:0]                          prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire logic [NUM_SRC-1:0]                   irqRequest,
  input wire irq_prio_pkg::src_cfg_t [NUM_SRC-1:0] sourceCfg,
  input wire logic [NUM_SRC-1:0]                   eligible
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic        wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
  wire logic        w6 = wr && apbReq.paddr == 8'h00;
  wire logic        w7 = wr && apbReq.paddr == 8'h04;
  wire logic        w8 = wr && apbReq.paddr == 8'h08;
  wire logic        r7 = apbReq.psel && !apbReq.penable && !apbReq.pwrite
                         && apbReq.paddr == 8'h04;
  wire logic [3:0]  s  = apbReq.pstrb;
  wire logic [31:0] d  = apbReq.pwdata;
  conv_map_a: assert property (
    w6 && s[3] |=> sourceCfg[3] == $past(d[28:24])) else $error("lane 3");
  change_map_a: assert property (
    w6 && s[2] |=> sourceCfg[2] == $past(d[20:16])) else $error("lane 2");
  cmp_map_a: assert property (
    w7 && s[1] |=> sourceCfg[5] == $past(d[12:8])) else $error("lane 5");
  serial_map_a: assert property (
    w8 && s[0] |=> sourceCfg[8] == $past(d[4:0])) else $error("lane 8");
  monitor_map_a: assert property (
    w8 && s[2] |=> sourceCfg[10] == $past(d[20:16])) else $error("lane 10");
  level_on_a: assert property (
    irqRequest[3] && sourceCfg[3].level == 3'h7 |=> eligible[3])
    else $error("level 7 not eligible");
  level_off_a: assert property (
    sourceCfg[7].level == 3'h0 |=> !eligible[7]) else $error("disabled");
  sub_read_a: assert property (
    r7 |=> prdata[25:24] == $past(sourceCfg[7].sublevel))
    else $error("sublevel read");
  reset_clear_a: assert property (
    $rose(rst_b) |-> sourceCfg == '0) else $error("reset value");
  cover property (w8 && s == 4'h4);
  cover property (eligible[3]);
  cover property (pslverr && pready);
endmodule : irq_prio_bank_sva
bind irq_priority_config_bank irq_prio_bank_sva #(.NUM_SRC(NUM_SRC))
  u_irq_prio_bank_sva (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqRequest(irqRequest), .sourceCfg(sourceCfg), .eligible(eligible));
`default_nettype wire

// ===== verif/irq_priority_config_bank_tb_top.sv
/* irq_priority_config_bank_tb_top: APB scenarios for the priority bank.
   Assumes the package and the bank are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,v) begin total_checks++; if ((v) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h seen %h", n, e, v); end end
module irq_priority_config_bank_tb_top;
  logic                            mclk = 1'b0;
  logic                            rst_b = 1'b0;
  irq_prio_pkg::apb_req_t          req = '0;
  logic [31:0]                     prdata, rd;
  logic                            pready, pslverr, slvErr;
  logic [11:0]                     irq = '0, eligible;
  irq_prio_pkg::src_cfg_t [11:0]   cfg;
  logic [31:0] pat [3] = '{32'h1D0E_1B07, 32'h1F05_0A13, 32'h0614_1E0B};
  int                              err_total = 0, total_checks = 0, cyc = 0;
  always #50 mclk = ~mclk;
  irq_priority_config_bank u_irq_priority_config_bank (.mclk(mclk),
    .rst_b(rst_b), .apbReq(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqRequest(irq), .sourceCfg(cfg),
    .eligible(eligible));
  // idle edge first, so psel never gets two assignments in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge mclk);
    req.penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    slvErr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task t_reset;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, 4'h0);
      `CHK("reset read", 32'h0, rd)
    end
  endtask : t_reset
  task t_map;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'(4 * i), pat[i], 4'hF);
      xfer(1'b0, 8'(4 * i), 32'h0, 4'h0);
      `CHK("readback", pat[i], rd)
      `CHK("mapped error", 1'b0, slvErr)
      for (int k = 0; k < 4; k++)
        `CHK("field", pat[i][8*k+:5], cfg[4*i+k])
    end
  endtask : t_map
  task t_elig;
    irq <= 12'hFFF;
    repeat (3) @(posedge mclk);
    `CHK("eligible", 12'hFFF, eligible)
    xfer(1'b1, 8'h08, 32'h0, 4'h4);
    repeat (3) @(posedge mclk);
    `CHK("eligible", 12'hBFF, eligible)
    `CHK("lane kept", 5'h06, cfg[11])
  endtask : t_elig
  task t_unmapped;
    xfer(1'b0, 8'h0C, 32'h0, 4'h0);
    `CHK("slave error", 1'b1, slvErr)
    `CHK("unmapped read", 32'h0, rd)
    `CHK("ready", 1'b1, pready)
  endtask : t_unmapped
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_map;
    t_elig;
    t_unmapped;
    conclude;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      conclude;
    end
  end
endmodule : irq_priority_config_bank_tb_top
`default_nettype wire
